// ### hdl/pattern_frame_defines.svh
// Register offsets, field positions, codes and reset values for the pattern and frame clock block
`ifndef PATTERN_FRAME_DEFINES_SVH
`define PATTERN_FRAME_DEFINES_SVH
`define ADDR_W 15
`define ADDR_PATTERN_VALUE_LOW 15'h0014
`define ADDR_PATTERN_VALUE_MID 15'h0015
`define ADDR_PATTERN_SELECT_AND_VALUE_HIGH 15'h0016
`define ADDR_FRAME_CLOCK_CONTROL 15'h0019
`define ADDR_OUTPUT_DRIVER_CONTROL 15'h001A
`define REG_RESET 8'h00
`define PAT_W 18
`define PAT_ZERO 18'h00000
`define SECOND_SEL_MSB 7
`define SECOND_SEL_LSB 5
`define FIRST_SEL_MSB 4
`define FIRST_SEL_LSB 2
`define VALUE_HIGH_MSB 1
`define SEL_NORMAL 3'h0
`define SEL_RAMP 3'h2
`define SEL_CONSTANT 3'h3
`define FRAME_SOURCE_BIT 7
`define FRAME_DIVIDE_BIT 4
`define FRAME_STRETCH_BIT 0
`define SWING_REDUCE_BIT 6
`define SPI_FRAME_BITS 5'h18
`define SPI_CMD_BITS 5'h10
`define SPI_CNT_ZERO 5'h00
`define SPI_CNT_ONE 5'h01
`define SPI_RD_FLAG_LAST 22
`define FRAME_CNT_ONE 2'h1
`define FRAME_CNT_ZERO 2'h0
`endif

// ### hdl/pattern_frame_pkg.sv
// Types shared by the pattern and frame clock block
package pattern_frame_pkg;
  typedef enum logic [2:0] {
    PH_IDLE = 3'b001,
    PH_CMD = 3'b010,
    PH_DATA = 3'b100
  } spi_phase_t;

  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_RAMP,
    MODE_CONSTANT
  } pattern_mode_t;

  typedef struct packed {
    logic sclk_s1;
    logic sclk_s2;
    logic sclk_s3;
    logic sen_n_s1;
    logic sen_n_s2;
    logic sdi_s1;
    logic sdi_s2;
    spi_phase_t phase;
    logic [4:0] bit_cnt;
    logic [22:0] shift_in;
    logic [7:0] shift_out;
    logic sdout;
    logic [7:0] pattern_value_low;
    logic [7:0] pattern_value_mid;
    logic [7:0] pattern_select_and_value_high;
    logic [7:0] frame_clock_control;
    logic [7:0] output_driver_control;
    logic [1:0][17:0] ramp_acc;
    logic [1:0] frame_cnt;
    logic frame_clock;
    logic swing_reduce;
  } top_state_t;
endpackage : pattern_frame_pkg

// ### hdl/sample_stream_if.sv
// Valid/ready carrier for the paired channel words between the core and its buffer
interface sample_stream_if #(parameter int WIDTH = 36);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport source (output valid, output data, input ready);
  modport sink (input valid, input data, output ready);
endinterface : sample_stream_if

// ### hdl/pair_buffer.sv
// Two-entry buffer whose output stage and ready are plain flip-flops
module pair_buffer #(
  parameter int WIDTH = 36
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Filling side
  sample_stream_if.sink fill,
  // Draining side
  output logic drain_valid_out,
  output logic [WIDTH-1:0] drain_data_out,
  input wire logic drain_ready_in
);
  typedef struct packed {
    logic [WIDTH-1:0] head;
    logic [WIDTH-1:0] tail;
    logic head_valid;
    logic tail_valid;
    logic in_ready;
  } buf_state_t;

  buf_state_t state_r;
  buf_state_t state_nxt;

  // Pop from head, shift tail forward, then push to the first free slot
  always_comb begin
    logic push;
    logic pop;
    push = fill.valid && state_r.in_ready;
    pop = state_r.head_valid && drain_ready_in;
    state_nxt = state_r;
    if (pop) begin
      state_nxt.head = state_r.tail;
      state_nxt.head_valid = state_r.tail_valid;
      state_nxt.tail_valid = 1'b0;
    end
    if (push) begin
      if (!state_nxt.head_valid) begin
        state_nxt.head = fill.data;
        state_nxt.head_valid = 1'b1;
      end else begin
        state_nxt.tail = fill.data;
        state_nxt.tail_valid = 1'b1;
      end
    end
    // Ready registered so the source sees a clean flop; costs no entry since tail is the reserve
    state_nxt.in_ready = !state_nxt.tail_valid;
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      state_r <= '0;
      state_r.in_ready <= 1'b1;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign fill.ready = state_r.in_ready;
  assign drain_valid_out = state_r.head_valid;
  assign drain_data_out = state_r.head;

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  AST_BUF_NO_LOSS: assert property (drain_valid_out && !drain_ready_in |=> drain_valid_out && $stable(drain_data_out))
    else $error("buffer head changed while stalled");
  AST_BUF_FULL_STALLS: assert property (state_r.tail_valid && state_r.head_valid |-> !fill.ready)
    else $error("buffer full but still ready");
  COV_BUF_FULL: cover property (state_r.tail_valid ##1 drain_ready_in);
endmodule : pair_buffer

// ### hdl/pattern_frame_top.sv
// Test pattern insertion, frame clock shaping and serial register port
`include "pattern_frame_defines.svh"

// Notes on behaviour
// - Constant mode outputs pattern value, MSB aligned
// - Ramp mode adds pattern value per sample
// - Second channel select bits 7-5 decode
// - First channel select bits 4-2, same codes
// - Insert before mapper at native MSB resolution
// - Source bit picks converter or decimation timing
// - Stretch bit spans both channel words
// - Swing bit halves driver current
module pattern_frame_top
  import pattern_frame_pkg::*;
#(
  parameter int SAMPLE_W = 18
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Serial control port, asynchronous to clk_sys_in
  input wire logic serial_clock_in,
  input wire logic serial_enable_n_in,
  input wire logic serial_data_in,
  output logic serial_data_out,
  // Converter samples, same clock domain
  input wire logic sample_valid_in,
  input wire logic [SAMPLE_W-1:0] first_sample_in,
  input wire logic [SAMPLE_W-1:0] second_sample_in,
  output logic sample_ready_out,
  // Paired output words toward the serializer
  output logic word_valid_out,
  output logic [2*SAMPLE_W-1:0] word_data_out,
  input wire logic word_ready_in,
  // Frame timing ticks and outputs
  input wire logic converter_frame_tick_in,
  input wire logic decimation_frame_tick_in,
  output logic frame_clock_out,
  output logic output_swing_reduce_out
);
  top_state_t state_r;
  top_state_t state_nxt;
  sample_stream_if #(.WIDTH(2 * SAMPLE_W)) stream ();

  // Select field decode, shared by both channels; unused codes fall back to normal
  function automatic pattern_mode_t decode_select(input logic [2:0] sel);
    pattern_mode_t m;
    m = MODE_NORMAL;
    if (sel == `SEL_RAMP) begin
      m = MODE_RAMP;
    end else if (sel == `SEL_CONSTANT) begin
      m = MODE_CONSTANT;
    end
    return m;
  endfunction : decode_select

  // Read-back mux; unmapped offsets answer zero
  function automatic logic [7:0] read_reg(input top_state_t s, input logic [14:0] a);
    logic [7:0] d;
    d = 8'h00;
    unique case (a)
      `ADDR_PATTERN_VALUE_LOW: d = s.pattern_value_low;
      `ADDR_PATTERN_VALUE_MID: d = s.pattern_value_mid;
      `ADDR_PATTERN_SELECT_AND_VALUE_HIGH: d = s.pattern_select_and_value_high;
      `ADDR_FRAME_CLOCK_CONTROL: d = s.frame_clock_control;
      `ADDR_OUTPUT_DRIVER_CONTROL: d = s.output_driver_control;
      default: d = 8'h00;
    endcase
    return d;
  endfunction : read_reg

  // Combined pattern value and per-channel modes
  logic [17:0] pattern_value;
  pattern_mode_t [1:0] chan_mode;
  logic [1:0][SAMPLE_W-1:0] chan_sample;
  logic [1:0][SAMPLE_W-1:0] chan_word;
  logic sample_take;
  logic sclk_rise;
  logic sclk_fall;
  logic frame_tick;
  logic [1:0] frame_limit;

  assign pattern_value = {state_r.pattern_select_and_value_high[`VALUE_HIGH_MSB:0],
                          state_r.pattern_value_mid, state_r.pattern_value_low};
  assign chan_mode[0] = decode_select(
    state_r.pattern_select_and_value_high[`FIRST_SEL_MSB:`FIRST_SEL_LSB]);
  assign chan_mode[1] = decode_select(
    state_r.pattern_select_and_value_high[`SECOND_SEL_MSB:`SECOND_SEL_LSB]);
  assign chan_sample[0] = first_sample_in;
  assign chan_sample[1] = second_sample_in;
  assign sample_take = sample_valid_in && stream.ready;

  // Pattern insertion per channel, ahead of any resolution mapping, MSB aligned
  generate
    for (genvar ch = 0; ch < 2; ch++) begin : g_chan
      always_comb begin
        unique case (chan_mode[ch])
          MODE_RAMP: chan_word[ch] = state_r.ramp_acc[ch][`PAT_W-1 -: SAMPLE_W];
          MODE_CONSTANT: chan_word[ch] = pattern_value[`PAT_W-1 -: SAMPLE_W];
          default: chan_word[ch] = chan_sample[ch];
        endcase
      end
    end
  endgenerate

  // Second channel in the upper half of the paired word
  assign stream.valid = sample_valid_in;
  assign stream.data = {chan_word[1], chan_word[0]};

  // Serial clock edges seen only after the two-stage synchroniser
  assign sclk_rise = state_r.sclk_s2 && !state_r.sclk_s3;
  assign sclk_fall = !state_r.sclk_s2 && state_r.sclk_s3;

  // Frame timing source and prescale
  assign frame_tick = state_r.frame_clock_control[`FRAME_SOURCE_BIT] ?
                      decimation_frame_tick_in : converter_frame_tick_in;
  assign frame_limit = {state_r.frame_clock_control[`FRAME_DIVIDE_BIT],
                        state_r.frame_clock_control[`FRAME_STRETCH_BIT]} == 2'b11 ? 2'h3 :
                       {1'b0, state_r.frame_clock_control[`FRAME_DIVIDE_BIT] |
                        state_r.frame_clock_control[`FRAME_STRETCH_BIT]};

  // Next state of the whole block
  always_comb begin
    logic [22:0] shifted;
    shifted = '0;
    state_nxt = state_r;
    state_nxt.sclk_s1 = serial_clock_in;
    state_nxt.sclk_s2 = state_r.sclk_s1;
    state_nxt.sclk_s3 = state_r.sclk_s2;
    state_nxt.sen_n_s1 = serial_enable_n_in;
    state_nxt.sen_n_s2 = state_r.sen_n_s1;
    state_nxt.sdi_s1 = serial_data_in;
    state_nxt.sdi_s2 = state_r.sdi_s1;

    // Serial frame: read flag, 15-bit address, 8 data bits, MSB first
    unique case (state_r.phase)
      PH_IDLE: begin
        state_nxt.bit_cnt = `SPI_CNT_ZERO;
        if (!state_r.sen_n_s2) begin
          state_nxt.phase = PH_CMD;
        end
      end
      PH_CMD: begin
        if (state_r.sen_n_s2) begin
          state_nxt.phase = PH_IDLE;
        end else if (sclk_rise) begin
          shifted = {state_r.shift_in[21:0], state_r.sdi_s2};
          state_nxt.shift_in = shifted;
          state_nxt.bit_cnt = state_r.bit_cnt + `SPI_CNT_ONE;
          if (state_r.bit_cnt + `SPI_CNT_ONE == `SPI_CMD_BITS) begin
            state_nxt.phase = PH_DATA;
            // Read data is captured once the address is complete
            state_nxt.shift_out = read_reg(state_r, shifted[14:0]);
          end
        end
      end
      PH_DATA: begin
        if (state_r.sen_n_s2) begin
          state_nxt.phase = PH_IDLE;
        end else if (sclk_fall) begin
          state_nxt.sdout = state_r.shift_out[7];
          state_nxt.shift_out = {state_r.shift_out[6:0], 1'b0};
        end else if (sclk_rise) begin
          shifted = {state_r.shift_in[21:0], state_r.sdi_s2};
          state_nxt.shift_in = shifted;
          state_nxt.bit_cnt = state_r.bit_cnt + `SPI_CNT_ONE;
          if (state_r.bit_cnt + `SPI_CNT_ONE == `SPI_FRAME_BITS) begin
            state_nxt.phase = PH_IDLE;
            // Writes commit only on a full frame with the read flag low; the flag has
            // already left the 23-bit register, so look at its place before this shift
            if (!state_r.shift_in[`SPI_RD_FLAG_LAST]) begin
              unique case (shifted[22:8])
                `ADDR_PATTERN_VALUE_LOW: state_nxt.pattern_value_low = shifted[7:0];
                `ADDR_PATTERN_VALUE_MID: state_nxt.pattern_value_mid = shifted[7:0];
                `ADDR_PATTERN_SELECT_AND_VALUE_HIGH: state_nxt.pattern_select_and_value_high = shifted[7:0];
                `ADDR_FRAME_CLOCK_CONTROL: state_nxt.frame_clock_control = shifted[7:0];
                `ADDR_OUTPUT_DRIVER_CONTROL: state_nxt.output_driver_control = shifted[7:0];
                default: ;
              endcase
            end
          end
        end
      end
      default: state_nxt.phase = PH_IDLE;
    endcase
    if (state_r.sen_n_s2) begin
      state_nxt.sdout = 1'b0;
    end

    // Ramp accumulators step on each accepted sample, wrap freely, clear outside ramp
    for (int ch = 0; ch < 2; ch++) begin
      if (chan_mode[ch] != MODE_RAMP) begin
        state_nxt.ramp_acc[ch] = `PAT_ZERO;
      end else if (sample_take) begin
        state_nxt.ramp_acc[ch] = state_r.ramp_acc[ch] + pattern_value;
      end
    end

    // Frame clock toggles after frame_limit+1 ticks of the chosen source
    if (frame_tick) begin
      if (state_r.frame_cnt >= frame_limit) begin
        state_nxt.frame_cnt = `FRAME_CNT_ZERO;
        state_nxt.frame_clock = !state_r.frame_clock;
      end else begin
        state_nxt.frame_cnt = state_r.frame_cnt + `FRAME_CNT_ONE;
      end
    end

    // Driver current halving level toward the pad
    state_nxt.swing_reduce = state_r.output_driver_control[`SWING_REDUCE_BIT];
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      state_r <= '0;
      state_r.phase <= PH_IDLE;
      state_r.sen_n_s1 <= 1'b1;
      state_r.sen_n_s2 <= 1'b1;
      state_r.pattern_value_low <= `REG_RESET;
      state_r.pattern_value_mid <= `REG_RESET;
      state_r.pattern_select_and_value_high <= `REG_RESET;
      state_r.frame_clock_control <= `REG_RESET;
      state_r.output_driver_control <= `REG_RESET;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Two-entry buffer so a stalled receiver loses no word
  pair_buffer #(.WIDTH(2 * SAMPLE_W)) u_buffer (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .fill(stream),
    .drain_valid_out(word_valid_out),
    .drain_data_out(word_data_out),
    .drain_ready_in(word_ready_in)
  );

  assign sample_ready_out = stream.ready;
  assign serial_data_out = state_r.sdout;
  assign frame_clock_out = state_r.frame_clock;
  assign output_swing_reduce_out = state_r.swing_reduce;

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  // Pattern, frame clock and swing checks; serial port framing is judged from the far side
  AST_CONSTANT_WORD: assert property (sample_take && chan_mode[0] == MODE_CONSTANT |->
    stream.data[SAMPLE_W-1:0] == pattern_value[`PAT_W-1 -: SAMPLE_W])
    else $error("constant pattern not on first channel");
  AST_SECOND_CONSTANT: assert property (sample_take && chan_mode[1] == MODE_CONSTANT |->
    stream.data[2*SAMPLE_W-1:SAMPLE_W] == pattern_value[`PAT_W-1 -: SAMPLE_W])
    else $error("constant pattern not on second channel");
  AST_RAMP_STEP: assert property (sample_take && chan_mode[1] == MODE_RAMP ##1 chan_mode[1] == MODE_RAMP
    && $stable(pattern_value) |-> state_r.ramp_acc[1] == 18'($past(state_r.ramp_acc[1]) + pattern_value))
    else $error("ramp did not advance by the increment");
  AST_SECOND_NORMAL: assert property (sample_valid_in &&
    state_r.pattern_select_and_value_high[`SECOND_SEL_MSB:`SECOND_SEL_LSB] == `SEL_NORMAL |->
    stream.data[2*SAMPLE_W-1:SAMPLE_W] == second_sample_in)
    else $error("second channel not passing samples");
  AST_FIRST_NORMAL: assert property (sample_valid_in &&
    state_r.pattern_select_and_value_high[`FIRST_SEL_MSB:`FIRST_SEL_LSB] == `SEL_NORMAL |->
    stream.data[SAMPLE_W-1:0] == first_sample_in)
    else $error("first channel not passing samples");
  AST_FIRST_RAMP: assert property (sample_valid_in &&
    state_r.pattern_select_and_value_high[`FIRST_SEL_MSB:`FIRST_SEL_LSB] == `SEL_RAMP |->
    stream.data[SAMPLE_W-1:0] == state_r.ramp_acc[0][`PAT_W-1 -: SAMPLE_W])
    else $error("first channel ramp not selected");
  AST_SOURCE_GATES: assert property (state_r.frame_clock_control[`FRAME_SOURCE_BIT] && !decimation_frame_tick_in
    |=> $stable(frame_clock_out) || $past(state_r.frame_clock_control[`FRAME_SOURCE_BIT]) == 1'b0)
    else $error("frame clock moved without decimation tick");
  AST_SOURCE_CONVERTER: assert property (!state_r.frame_clock_control[`FRAME_SOURCE_BIT] &&
    !converter_frame_tick_in |=> $stable(frame_clock_out))
    else $error("frame clock moved without converter tick");
  AST_STRETCH_TWO: assert property (state_r.frame_clock_control[`FRAME_STRETCH_BIT] &&
    !state_r.frame_clock_control[`FRAME_DIVIDE_BIT] && frame_tick && state_r.frame_cnt == `FRAME_CNT_ZERO
    |=> $stable(frame_clock_out))
    else $error("stretched frame clock toggled on first tick");
  AST_SWING_FOLLOWS: assert property (##1 output_swing_reduce_out ==
    $past(state_r.output_driver_control[`SWING_REDUCE_BIT]))
    else $error("swing output does not follow register");
  AST_RAMP_WRAP: assert property (sample_take && chan_mode[0] == MODE_RAMP ##1 chan_mode[0] == MODE_RAMP
    |-> state_r.ramp_acc[0] == 18'($past(state_r.ramp_acc[0]) + $past(pattern_value)))
    else $error("ramp failed to wrap");
  AST_READY_STALL: assert property (!sample_ready_out && sample_valid_in |=> $stable(state_r.ramp_acc)
    || $changed(state_r.pattern_select_and_value_high))
    else $error("ramp advanced on a refused sample");

  // Main scenarios: ramp streaming, constant word, register write, decimation-timed frame clock
  COV_RAMP: cover property (sample_take && chan_mode[1] == MODE_RAMP [*3]);
  COV_CONSTANT: cover property (sample_take && chan_mode[0] == MODE_CONSTANT);
  COV_WRITE: cover property (state_r.phase == PH_DATA ##1 state_r.phase == PH_IDLE);
  COV_FRAME_DDC: cover property (state_r.frame_clock_control[`FRAME_SOURCE_BIT] && $changed(frame_clock_out));
endmodule : pattern_frame_top

// ### testbench/word_receiver.sv
// Receiving-side model that captures paired words and can stall
module word_receiver (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Stall request from the bench
  input wire logic stall_in,
  // Word stream from the block
  input wire logic valid_in,
  input wire logic [35:0] data_in,
  output logic ready_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] cnt_r;
  logic [35:0] got[$];

  // Capture on handshake; when stalling, accept only one cycle in four
  always @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_r <= 2'h0;
      ready_out <= 1'b0;
    end else begin
      if (valid_in && ready_out) got.push_back(data_in);
      cnt_r <= cnt_r + 2'h1;
      ready_out <= !stall_in || (cnt_r == 2'h3);
    end
  end
endmodule : word_receiver

// ### testbench/test_pattern_frame_clock_cfg_bench.sv
// Self-checking bench for the pattern and frame clock block
module test_pattern_frame_clock_cfg_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic sck = 1'b0;
  logic sen_n = 1'b1;
  logic sdi = 1'b0;
  logic sv = 1'b0;
  logic [17:0] fs = 18'h00000;
  logic [17:0] ss = 18'h00000;
  logic ct = 1'b0;
  logic dt = 1'b0;
  logic stall = 1'b0;
  logic sdo, srdy, wv, wr, fco, swing, fco_q;
  logic [35:0] wd;
  logic seen_full = 1'b0;
  logic [14:0] adr [5] = '{15'h0014, 15'h0015, 15'h0016, 15'h0019, 15'h001A};
  int fails = 0;
  int checks = 0;
  int togs = 0;

  pattern_frame_top DUT (.clk_sys_in(clk), .rst_in(rst), .serial_clock_in(sck), .serial_enable_n_in(sen_n),
    .serial_data_in(sdi), .serial_data_out(sdo), .sample_valid_in(sv), .first_sample_in(fs),
    .second_sample_in(ss), .sample_ready_out(srdy), .word_valid_out(wv), .word_data_out(wd),
    .word_ready_in(wr), .converter_frame_tick_in(ct), .decimation_frame_tick_in(dt),
    .frame_clock_out(fco), .output_swing_reduce_out(swing));

  word_receiver rx (.clk_sys_in(clk), .rst_in(rst), .stall_in(stall), .valid_in(wv), .data_in(wd),
    .ready_out(wr));

  // 125 MHz system clock
  initial begin
    forever #4 clk = ~clk;
  end

  // Toggle counter and full-buffer witness
  always @(posedge clk) begin
    fco_q <= fco;
    if (fco !== fco_q) togs++;
    if (sv && srdy === 1'b0) seen_full = 1'b1;
  end

  task automatic end_sim;
    if (fails == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t mismatch got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // One 24-bit frame, 64 ns serial period; clock idles low between frames
  task automatic spi(input logic rd, input logic [14:0] a, input logic [7:0] d, output logic [7:0] q);
    logic [23:0] f;
    f = {rd, a, d};
    q = 8'h00;
    sen_n <= 1'b0;
    for (int i = 23; i >= 0; i--) begin
      sdi <= f[i];
      repeat (4) @(posedge clk);
      sck <= 1'b1;
      @(negedge clk);
      if (i < 8) q[i] = sdo;
      repeat (4) @(posedge clk);
      sck <= 1'b0;
    end
    repeat (6) @(posedge clk);
    sen_n <= 1'b1;
    repeat (6) @(posedge clk);
  endtask : spi

  function automatic logic [17:0] expv(input logic [2:0] m, input logic [17:0] v, input logic [17:0] smp,
    input int i);
    case (m)
      3'h3: return v;
      3'h2: return 18'(i * v);
      default: return smp;
    endcase
  endfunction : expv

  // Reset values, read-back, unmapped place and swing output
  task automatic reg_case;
    logic [7:0] q;
    for (int k = 0; k < 5; k++) begin
      spi(1'b1, adr[k], 8'hFF, q);
      chk(36'(q), 36'h0);
      // Junk data in a read frame must not land
      spi(1'b1, adr[k], 8'h00, q);
      chk(36'(q), 36'h0);
      spi(1'b0, adr[k], 8'hA5, q);
      spi(1'b1, adr[k], 8'h00, q);
      chk(36'(q), 36'hA5);
      spi(1'b0, adr[k], 8'h00, q);
    end
    spi(1'b0, 15'h0017, 8'hFF, q);
    spi(1'b1, 15'h0017, 8'h00, q);
    chk(36'(q), 36'h0);
    spi(1'b0, 15'h001A, 8'h40, q);
    chk(36'(swing), 36'h1);
    spi(1'b0, 15'h001A, 8'hBF, q);
    chk(36'(swing), 36'h0);
  endtask : reg_case

  task automatic pulse(input logic conv);
    if (conv) ct <= 1'b1;
    else dt <= 1'b1;
    @(posedge clk);
    ct <= 1'b0;
    dt <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : pulse

  // Source, divide and stretch settings against counted toggles
  task automatic frame_clock_case;
    logic [7:0] q;
    logic [7:0] ctl [4] = '{8'h00, 8'h80, 8'h10, 8'h01};
    int ec [4] = '{4, 0, 2, 2};
    int ed [4] = '{0, 4, 0, 0};
    for (int k = 0; k < 4; k++) begin
      spi(1'b0, 15'h0019, ctl[k], q);
      togs = 0;
      repeat (4) pulse(1'b1);
      chk(36'(togs), 36'(ec[k]));
      togs = 0;
      repeat (4) pulse(1'b0);
      chk(36'(togs), 36'(ed[k]));
    end
  endtask : frame_clock_case

  // Streams n sample pairs back to back under a pattern setting
  task automatic pat_case(input logic [2:0] m2, input logic [2:0] m1, input logic [17:0] v, input int n,
    input logic st);
    logic [7:0] q;
    spi(1'b0, 15'h0014, v[7:0], q);
    spi(1'b0, 15'h0015, v[15:8], q);
    spi(1'b0, 15'h0016, {m2, m1, v[17:16]}, q);
    rx.got.delete();
    seen_full = 1'b0;
    stall <= st;
    for (int i = 0; i < n; i++) begin
      sv <= 1'b1;
      fs <= 18'(i * 37 + 5);
      ss <= 18'(i * 91 + 2);
      do @(negedge clk); while (srdy !== 1'b1);
      @(posedge clk);
    end
    sv <= 1'b0;
    stall <= 1'b0;
    for (int t = 0; t < 60 && rx.got.size() < n; t++) @(posedge clk);
    chk(36'(rx.got.size()), 36'(n));
    for (int i = 0; i < n && i < rx.got.size(); i++) begin
      chk(36'(rx.got[i][17:0]), 36'(expv(m1, v, 18'(i * 37 + 5), i)));
      chk(36'(rx.got[i][35:18]), 36'(expv(m2, v, 18'(i * 91 + 2), i)));
    end
    if (st) chk(36'(seen_full), 36'h1);
  endtask : pat_case

  // Main sequence
  initial begin
    logic [7:0] q;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    // Interface select and fuse load pulse go first; both are unmapped here
    spi(1'b0, 15'h0007, 8'h00, q);
    spi(1'b0, 15'h0013, 8'h01, q);
    spi(1'b0, 15'h0013, 8'h00, q);
    reg_case();
    frame_clock_case();
    pat_case(3'h3, 3'h5, 18'h2A5C3, 4, 1'b0);
    pat_case(3'h2, 3'h2, 18'h00001, 6, 1'b1);
    pat_case(3'h0, 3'h3, 18'h15A3C, 3, 1'b0);
    pat_case(3'h2, 3'h0, 18'h31000, 6, 1'b0);
    end_sim();
  end

  // Watchdog: the sequence needs well under 20k cycles
  initial begin
    #400000;
    fails++;
    end_sim();
  end
endmodule : test_pattern_frame_clock_cfg_bench
